/* res_map.vh */
// Constants for the receiver eye-scan sequencer: port addresses,
// state codes, control field positions and scale steps.
// Assumes inclusion by res_sequencer.v only; definitions only.
//
// How it works
// R01 - Run bit in waiting starts error-rate measurement
// R02 - Arm bit in waiting starts diagnostic capture
// R03 - Clearing arm while armed forces read state
// R04 - Trigger 0001: unmasked one on offset bus
// R05 - Trigger 0010: masked qualifier matches recovered data
// R06 - Trigger 0100: external trigger input high
// R07 - Status bit zero high in waiting/end/read
// R08 - Status bits three-one report state code
// R09 - Trigger freezes recovered capture, current low, previous high
// R10 - Trigger freezes offset capture, current low, previous high
// R11 - Totals hold final values in end/waiting
// R12 - Outside sets legal fabric width values
// R13 - Override picks phase bit, else detector phase
// R14 - Valid bits equal width over two^(1-select)
// R15 - Offset from sign, direction, 7-bit magnitude
// R16 - Scale code selects 1.5/1.8/2.2/2.8 mV step
// R17 - Totals, status, captures read-only at 151-15D
// R18 - Reset state clears counters, then count/armed
// R19 - Counter saturation stops both, goes to end
// R20 - End returns to waiting when run cleared
// R21 - Control bits five-two choose trigger source
// R22 - Read returns to waiting once arm cleared

`ifndef RES_MAP_VH
`define RES_MAP_VH

// ****************************************************************
// Configuration port addresses
// ****************************************************************
`define RES_ADDR_W 9
`define RES_ADDR_ERROR_TOTAL 9'h151
`define RES_ADDR_SAMPLE_TOTAL 9'h152
`define RES_ADDR_STATE_STATUS 9'h153
`define RES_ADDR_RCAP_WORD4 9'h154
`define RES_ADDR_RCAP_WORD3 9'h155
`define RES_ADDR_RCAP_WORD2 9'h156
`define RES_ADDR_RCAP_WORD1 9'h157
`define RES_ADDR_RCAP_WORD0 9'h158
`define RES_ADDR_OCAP_WORD4 9'h159
`define RES_ADDR_OCAP_WORD3 9'h15a
`define RES_ADDR_OCAP_WORD2 9'h15b
`define RES_ADDR_OCAP_WORD1 9'h15c
`define RES_ADDR_OCAP_WORD0 9'h15d

// ****************************************************************
// State codes, as shown in status bits three to one
// ****************************************************************
`define RES_ST_WAIT 3'h0
`define RES_ST_RESET 3'h1
`define RES_ST_COUNT 3'h3
`define RES_ST_END 3'h2
`define RES_ST_ARMED 3'h5
`define RES_ST_READ 3'h4

// ****************************************************************
// Control field layout and trigger selections
// ****************************************************************
`define RES_CTL_RUN 0
`define RES_CTL_ARM 1
`define RES_CTL_TRIG_HI 5
`define RES_CTL_TRIG_LO 2
`define RES_TRIG_ERROR 4'h1
`define RES_TRIG_QUAL 4'h2
`define RES_TRIG_PORT 4'h4
`define RES_TRIG_FORCE 4'h8

// ****************************************************************
// Bus widths, saturation and vertical scale steps (tenths of mV)
// ****************************************************************
`define RES_BUS_W 40
`define RES_TOTAL_MAX 16'hffff
`define RES_STEP_00 5'h0f
`define RES_STEP_01 5'h12
`define RES_STEP_10 5'h16
`define RES_STEP_11 5'h1c

`endif

/* res_sequencer.v */
// Eye-scan sequencer: state machine, counters, two-cycle captures
// and the read-only configuration port window.
// Assumes all inputs are synchronous to clk, the receive user clock;
// masks, qualifier and prescale come from the margin unit settings.
`timescale 1ns/1ps
`include "res_map.vh"

module res_sequencer (
  input wire clk,
  input wire reset_n,
  // Configuration port, read-only window
  input wire dcpEn,
  input wire dcpWe,
  input wire [8:0] dcpAddr,
  output reg [15:0] dcpDo,
  output reg dcpRdy,
  // Scan control and settings
  input wire [5:0] scanControl,
  input wire extTrigger,
  input wire [4:0] prescale,
  input wire [79:0] sampleMask,
  input wire [79:0] qualPattern,
  input wire [79:0] qualMask,
  input wire internalWidthSelect,
  input wire [6:0] rxDataWidth,
  input wire phaseSelectOverride,
  input wire quarterClockPhase,
  input wire detectorPhase,
  input wire thresholdSign,
  input wire offsetDirection,
  input wire [6:0] offsetMagnitude,
  input wire [1:0] verticalScale,
  // Sample buses from the margin unit
  input wire [39:0] recoveredData,
  input wire [39:0] offsetSample,
  // Outputs toward the margin unit
  output reg scanPhase,
  output reg [6:0] validWidth,
  output reg [8:0] verticalOffset,
  output reg [4:0] scaleStep,
  output reg dataError
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Number of ones on a 40-bit word
  function [5:0] onesCount;
    input [39:0] word;
    integer i;
    begin
      onesCount = 6'h00;
      for (i = 0; i < `RES_BUS_W; i = i + 1) begin
        onesCount = onesCount + {5'h00, word[i]};
      end
    end
  endfunction

  // Saturating add of a small amount to a 16-bit total
  function [15:0] satAdd;
    input [15:0] total;
    input [5:0] amount;
    reg [16:0] sum;
    begin
      sum = {1'b0, total} + {11'h000, amount};
      satAdd = sum[16] ? `RES_TOTAL_MAX : sum[15:0];
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] errTotal_r;
  reg [15:0] sampleTotal_r;
  reg [31:0] prescaleCnt_r;
  reg [39:0] prevRec_r;
  reg [39:0] prevOff_r;
  reg [79:0] recCapture_r;
  reg [79:0] offCapture_r;
  reg [15:0] readWord;

  wire runBit = scanControl[`RES_CTL_RUN];
  wire armBit = scanControl[`RES_CTL_ARM];
  wire [3:0] trigSel = scanControl[`RES_CTL_TRIG_HI:`RES_CTL_TRIG_LO];

  // ****************************************************************
  // Error and qualifier detection
  // ****************************************************************

  // Current cycle counts each unmasked one; previous cycle counts once
  wire [39:0] curUnmasked = offsetSample & ~sampleMask[39:0];
  wire [39:0] prevUnmasked = prevOff_r & ~sampleMask[79:40];
  wire anyError = (|curUnmasked) | (|prevUnmasked);
  wire [5:0] curErrors = onesCount(curUnmasked);
  wire [5:0] errAmount = curErrors + {5'h00, |prevUnmasked};

  // Qualifier compares both cycles of recovered data under the mask
  wire qualMatch = ~|(({prevRec_r, recoveredData} ^ qualPattern) & ~qualMask);

  // Prescale period is 2^(1+prescale) cycles; wide enough for 2^32
  wire [32:0] prescaleEnd = (33'h000000001 << (6'h01 + {1'b0, prescale})) - 33'h1;
  wire prescaleHit = ({1'b0, prescaleCnt_r} == prescaleEnd);

  wire saturated = (errTotal_r == `RES_TOTAL_MAX) | (sampleTotal_r == `RES_TOTAL_MAX);

  // Trigger source choice while armed
  reg trigHit;
  always @* begin
    case (trigSel) // R21
      `RES_TRIG_ERROR: trigHit = |curUnmasked; // R04
      `RES_TRIG_QUAL: trigHit = qualMatch; // R05
      `RES_TRIG_PORT: trigHit = extTrigger; // R06
      `RES_TRIG_FORCE: trigHit = 1'b1;
      default: trigHit = 1'b0;
    endcase
  end

  // ****************************************************************
  // State machine
  // ****************************************************************

  // Next state; run takes priority over arm when both are set
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `RES_ST_WAIT: begin
        if (runBit | armBit) begin
          state_nxt = `RES_ST_RESET; // R01 R02
        end
      end
      `RES_ST_RESET: begin
        if (runBit) begin
          state_nxt = `RES_ST_COUNT; // R18
        end else if (armBit) begin
          state_nxt = `RES_ST_ARMED; // R18
        end else begin
          state_nxt = `RES_ST_WAIT;
        end
      end
      `RES_ST_COUNT: begin
        if (saturated) begin
          state_nxt = `RES_ST_END; // R19
        end
      end
      `RES_ST_END: begin
        if (!runBit) begin
          state_nxt = `RES_ST_WAIT; // R20
        end
      end
      `RES_ST_ARMED: begin
        if (trigHit | !armBit) begin
          state_nxt = `RES_ST_READ; // R03
        end
      end
      `RES_ST_READ: begin
        if (!armBit) begin
          state_nxt = `RES_ST_WAIT; // R22
        end
      end
      default: state_nxt = `RES_ST_WAIT;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= `RES_ST_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Counters
  // ****************************************************************

  // Totals only count in the counting state, so they hold afterwards
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      errTotal_r <= 16'h0000;
      sampleTotal_r <= 16'h0000;
      prescaleCnt_r <= 32'h00000000;
    end else if (state_r == `RES_ST_RESET) begin
      errTotal_r <= 16'h0000; // R18
      sampleTotal_r <= 16'h0000; // R18
      prescaleCnt_r <= 32'h00000000;
    end else if (state_r == `RES_ST_COUNT && !saturated) begin // R19
      if (qualMatch) begin
        errTotal_r <= satAdd(errTotal_r, errAmount);
        if (prescaleHit) begin
          prescaleCnt_r <= 32'h00000000;
          sampleTotal_r <= satAdd(sampleTotal_r, 6'h01);
        end else begin
          prescaleCnt_r <= prescaleCnt_r + 32'h00000001;
        end
      end
    end
  end

  // ****************************************************************
  // Two-cycle capture
  // ****************************************************************

  // History always runs; the capture copy freezes on leaving armed
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevRec_r <= 40'h0000000000;
      prevOff_r <= 40'h0000000000;
      recCapture_r <= 80'h0;
      offCapture_r <= 80'h0;
    end else begin
      prevRec_r <= recoveredData;
      prevOff_r <= offsetSample;
      if (state_r == `RES_ST_ARMED) begin
        recCapture_r <= {prevRec_r, recoveredData}; // R09
        offCapture_r <= {prevOff_r, offsetSample}; // R10
      end
    end
  end

  // ****************************************************************
  // Configuration port reads
  // ****************************************************************

  // Writes are acknowledged but change nothing: the window is read-only
  always @* begin
    case (dcpAddr) // R17
      `RES_ADDR_ERROR_TOTAL: readWord = errTotal_r; // R11
      `RES_ADDR_SAMPLE_TOTAL: readWord = sampleTotal_r; // R11
      `RES_ADDR_STATE_STATUS: begin
        readWord = {12'h000, state_r, // R08
          (state_r == `RES_ST_WAIT) | (state_r == `RES_ST_END) |
          (state_r == `RES_ST_READ)}; // R07
      end
      `RES_ADDR_RCAP_WORD4: readWord = recCapture_r[79:64];
      `RES_ADDR_RCAP_WORD3: readWord = recCapture_r[63:48];
      `RES_ADDR_RCAP_WORD2: readWord = recCapture_r[47:32];
      `RES_ADDR_RCAP_WORD1: readWord = recCapture_r[31:16];
      `RES_ADDR_RCAP_WORD0: readWord = recCapture_r[15:0];
      `RES_ADDR_OCAP_WORD4: readWord = offCapture_r[79:64];
      `RES_ADDR_OCAP_WORD3: readWord = offCapture_r[63:48];
      `RES_ADDR_OCAP_WORD2: readWord = offCapture_r[47:32];
      `RES_ADDR_OCAP_WORD1: readWord = offCapture_r[31:16];
      `RES_ADDR_OCAP_WORD0: readWord = offCapture_r[15:0];
      default: readWord = 16'h0000;
    endcase
  end

  // One-cycle answer to every enabled access
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dcpDo <= 16'h0000;
      dcpRdy <= 1'b0;
    end else begin
      dcpRdy <= dcpEn;
      if (dcpEn && !dcpWe) begin
        dcpDo <= readWord;
      end
    end
  end

  // ****************************************************************
  // Settings toward the margin unit
  // ****************************************************************

  // Registered so every output leaves a flip-flop
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scanPhase <= 1'b0;
      validWidth <= 7'h00;
      verticalOffset <= 9'h000;
      scaleStep <= `RES_STEP_00;
      dataError <= 1'b0;
    end else begin
      scanPhase <= phaseSelectOverride ? quarterClockPhase : detectorPhase; // R13
      validWidth <= internalWidthSelect ? rxDataWidth : {1'b0, rxDataWidth[6:1]}; // R14
      verticalOffset <= {thresholdSign, offsetDirection, offsetMagnitude}; // R15
      case (verticalScale) // R16
        2'h0: scaleStep <= `RES_STEP_00;
        2'h1: scaleStep <= `RES_STEP_01;
        2'h2: scaleStep <= `RES_STEP_10;
        default: scaleStep <= `RES_STEP_11;
      endcase
      dataError <= anyError &
        ((state_r == `RES_ST_COUNT) | (state_r == `RES_ST_ARMED));
    end
  end

endmodule

/* res_sequencer_asserts.sv */
// Checker for the eye-scan sequencer, watching the top ports only.
// Assumes a single clk domain with asynchronous active-low reset_n.
`timescale 1ns/1ps
// ****
// Port and settings checks
// ****
module res_sequencer_asserts (
  input wire clk,
  input wire reset_n,
  input wire dcpEn,
  input wire dcpWe,
  input wire [8:0] dcpAddr,
  input wire [15:0] dcpDo,
  input wire dcpRdy,
  input wire internalWidthSelect,
  input wire [6:0] rxDataWidth,
  input wire phaseSelectOverride,
  input wire quarterClockPhase,
  input wire detectorPhase,
  input wire thresholdSign,
  input wire offsetDirection,
  input wire [6:0] offsetMagnitude,
  input wire [1:0] verticalScale,
  input wire scanPhase,
  input wire [6:0] validWidth,
  input wire [8:0] verticalOffset,
  input wire [4:0] scaleStep
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Read strobe and expected step, tenths of mV
  wire rdEn = dcpEn && !dcpWe;
  wire [4:0] stepExp = verticalScale[1] ? (verticalScale[0] ? 5'h1c : 5'h16)
                                        : (verticalScale[0] ? 5'h12 : 5'h0f);
  rdy_follows_en_a: assert property (dcpEn |=> dcpRdy)
    else $error("ready missing after access");
  rdy_one_cycle_a: assert property ((dcpEn ##1 !dcpEn) |=> !dcpRdy)
    else $error("ready stretched");
  unmapped_zero_a: assert property ((rdEn && (dcpAddr < 9'h151 || dcpAddr > 9'h15d))
    |=> dcpDo == 16'h0000) else $error("unmapped read not zero");
  status_code_a: assert property ((rdEn && dcpAddr == 9'h153) |=> dcpDo[15:4] == 12'h000
    && dcpDo[3:2] != 2'h3 && dcpDo[0] == (dcpDo[3:1] inside {3'h0, 3'h2, 3'h4}))
    else $error("status code or done wrong");
  // Registered settings; first edge after reset still shows reset values
  scale_step_a: assert property ($past(reset_n) |-> scaleStep == $past(stepExp))
    else $error("scale step wrong");
  phase_follow_a: assert property ($past(reset_n) |-> scanPhase ==
    $past(phaseSelectOverride ? quarterClockPhase : detectorPhase)) else $error("phase wrong");
  offset_follow_a: assert property ($past(reset_n) |-> verticalOffset ==
    $past({thresholdSign, offsetDirection, offsetMagnitude})) else $error("offset wrong");
  width_follow_a: assert property ($past(reset_n) |-> validWidth ==
    $past(internalWidthSelect ? rxDataWidth : rxDataWidth >> 1)) else $error("width wrong");
  cover property (rdEn && dcpAddr == 9'h153 ##1 dcpDo[3:0] == 4'h5);
  cover property (rdEn && dcpAddr == 9'h153 ##1 dcpDo[3:0] == 4'h9);
  cover property (scaleStep == 5'h1c);
endmodule

bind res_sequencer res_sequencer_asserts u_res_sequencer_asserts (.*);

/* res_fabric_host.sv */
// Fabric-side model of the configuration port master.
// Assumes the testbench calls access() hierarchically, one at a time.
`timescale 1ns/1ps
// ****
// Configuration port master
// ****
module res_fabric_host (
  input wire clk,
  input wire [15:0] dcpDo,
  input wire dcpRdy,
  output logic dcpEn = 1'b0,
  output logic dcpWe = 1'b0,
  output logic [8:0] dcpAddr = 9'h000
);
  // One-cycle strobe; unanswered access hands back unknown data
  task automatic access(input logic we, input logic [8:0] a, output logic [15:0] d);
    @(posedge clk);
    #1 dcpEn = 1'b1;
    dcpWe = we;
    dcpAddr = a;
    @(posedge clk);
    #1 dcpEn = 1'b0;
    dcpWe = 1'b0;
    dcpAddr = ~a; // Driven to the inverted address, so no stale address
    d = (dcpRdy === 1'b1) ? dcpDo : 16'hxxxx;
  endtask
endmodule

/* test_rx_eye_scan_sequencer.sv */
// Self-checking bench for the eye-scan sequencer.
// Assumes res_sequencer, its checker and res_fabric_host are compiled first.
`timescale 1ns/1ps
// ****
// Bench
// ****
module test_rx_eye_scan_sequencer;
  localparam logic [39:0] QW = 40'h5a5a5a5a5a, R1 = 40'h0123456789;
  localparam logic [39:0] R2 = 40'hfedcba9876, O2 = 40'h8000000001;
  logic clk = 1'b0, reset_n = 1'b0, extTrigger = 1'b0, internalWidthSelect = 1'b0;
  logic phaseSelectOverride = 1'b0, quarterClockPhase = 1'b0, detectorPhase = 1'b0;
  logic thresholdSign = 1'b0, offsetDirection = 1'b0;
  logic dcpEn, dcpWe, dcpRdy, scanPhase, dataError;
  logic [1:0] verticalScale = 2'h0;
  logic [4:0] prescale = 5'h00, scaleStep;
  logic [5:0] scanControl = 6'h00;
  logic [6:0] rxDataWidth = 7'h28, offsetMagnitude = 7'h00, validWidth;
  logic [8:0] dcpAddr, verticalOffset;
  logic [15:0] dcpDo, rd;
  logic [39:0] recoveredData = QW, offsetSample = 40'h0;
  logic [79:0] sampleMask = {{40{1'b1}}, 40'h0}, qualPattern = {40'h0, R2}, qualMask = '1;
  logic [79:0] er, eo;
  logic [3:0] tc;
  logic [3:0] codes[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
  logic [4:0] stp[4] = '{5'h0f, 5'h12, 5'h16, 5'h1c};
  logic [6:0] wd[6] = '{7'h10, 7'h14, 7'h20, 7'h28, 7'h40, 7'h50};
  int failures = 0, checks = 0;

  res_sequencer u_res_sequencer (.*);
  res_fabric_host u_res_fabric_host (.*);

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdk(input logic [8:0] a, input logic [15:0] e, input string nm);
    u_res_fabric_host.access(1'b0, a, rd);
    chk(nm, e, rd);
  endtask

  // Poll status; bounded so a stuck state shows as a mismatch
  task automatic waitSt(input logic [3:0] e, input int lim);
    for (int n = 0; n < lim; n++) begin
      u_res_fabric_host.access(1'b0, 9'h153, rd);
      if (rd === {12'h000, e}) break;
    end
    chk("status", {12'h000, e}, rd);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 2000 cycles the tests need
  initial begin
    #400000;
    failures++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    waitSt(4'h1, 1);
    rdk(9'h150, 16'h0000, "unmapped");
    u_res_fabric_host.access(1'b1, 9'h151, rd);
    rdk(9'h151, 16'h0000, "error total");
    // Settings outputs over every legal width and scale code
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) #1 rxDataWidth = wd[i];
      internalWidthSelect = (i == 2 || i > 3);
      verticalScale = i[1:0];
      phaseSelectOverride = i[0];
      quarterClockPhase = i[1];
      detectorPhase = !i[1];
      thresholdSign = i[1];
      offsetDirection = i[0];
      offsetMagnitude = 7'h3f + i[6:0];
      @(posedge clk) #1 chk("width", internalWidthSelect ? wd[i] : wd[i] >> 1, validWidth);
      chk("scale", stp[i[1:0]], scaleStep);
      chk("phase", i[0] ? i[1] : !i[1], scanPhase);
      chk("voffset", {i[1], i[0], 7'h3f + i[6:0]}, verticalOffset);
    end
    // Error-rate run: 40 errors a cycle saturate errors after 1639 cycles
    offsetSample = {40{1'b1}};
    scanControl = 6'h01;
    waitSt(4'h5, 1200);
    rdk(9'h151, 16'hffff, "error total");
    // Errors still on the bus, but the end state must not flag them
    chk("data error", 16'h0000, {15'h0, dataError});
    u_res_fabric_host.access(1'b0, 9'h152, rd);
    chk("sample band", 16'h0001, {15'h0, rd > 16'h0331 && rd < 16'h0335});
    scanControl = 6'h00;
    offsetSample = 40'h0;
    waitSt(4'h1, 4);
    rdk(9'h151, 16'hffff, "error total");
    // Diagnostic runs, one per trigger code, then one never triggering
    qualMask = {{40{1'b1}}, 40'h0};
    for (int c = 0; c < 5; c++) begin
      tc = codes[c];
      er = (tc == 4'h8 || tc == 4'h0) ? {QW, QW} : {R1, R2};
      eo = (tc == 4'h8 || tc == 4'h0) ? 80'h0 : {40'h0, O2};
      scanControl = {tc, 2'b10};
      if (tc != 4'h8) begin
        waitSt(4'ha, 4);
        @(posedge clk) #1 recoveredData = R1;
        @(posedge clk) #1 recoveredData = R2;
        offsetSample = O2;
        extTrigger = tc[2];
        @(posedge clk) #1 recoveredData = QW;
        offsetSample = 40'h0;
        extTrigger = 1'b0;
        // Unmasked one seen while armed raises the error pulse
        chk("data error", 16'h0001, {15'h0, dataError});
      end
      if (tc == 4'h0) begin
        rdk(9'h153, 16'h000a, "status");
        scanControl = 6'h00;
      end
      waitSt(tc == 4'h0 ? 4'h1 : 4'h9, 4);
      for (int k = 0; k < 5; k++) begin
        rdk(9'h154 + 9'(k), er[79 - 16 * k -: 16], "recovered word");
        rdk(9'h159 + 9'(k), eo[79 - 16 * k -: 16], "offset word");
      end
      scanControl = 6'h00;
      waitSt(4'h1, 4);
    end
    rdk(9'h151, 16'h0000, "error total");
    close_out();
  end
endmodule
